/* File: core/ech_defs.svh */
// Constants for the echo canceller control register bank
`ifndef ECH_DEFS_SVH
`define ECH_DEFS_SVH

// Avalon byte offsets
`define ECH_OFS_CMD 4'h0
`define ECH_OFS_WORD1 4'h4
`define ECH_OFS_WORD2 4'h8
`define ECH_OFS_STAT 4'hc

// Destination codes in the low nibble of a control word
`define ECH_CODE_FIELD 3:0
`define ECH_CODE_WORD1 4'h2
`define ECH_CODE_WORD2 4'h4

// Reset images of both control words
`define ECH_WORD1_RST 16'h2a02
`define ECH_WORD2_RST 16'h0004

// Word 1 fields
`define ECH_W1_TX_THR 15:14
`define ECH_W1_TAPS 13:12
`define ECH_W1_TX_GAIN 11:8
`define ECH_W1_SQUELCH_OFF 7
`define ECH_W1_COEFF 6:5
`define ECH_W1_REENGAGE_OFF 4

// Word 2 fields
`define ECH_W2_RX_THR 15:14
`define ECH_W2_SQUELCH_THR 13:12
`define ECH_W2_NOISE_RISE 11:10
`define ECH_W2_HOLDOVER 9:8
`define ECH_W2_HOWL_HOLD 7
`define ECH_W2_TX_DECAY 6
`define ECH_W2_RX_DECAY 5
`define ECH_W2_IDLE_TX 4

// Detector thresholds: 6 dB plus 3 dB per code step
`define ECH_THR_BASE_DB 9'h006
`define ECH_THR_STEP_DB 9'h003

// Tap split: line taps are 64 per code step plus 64, acoustic gets the rest
`define ECH_TAPS_TOTAL 10'h1fc
`define ECH_TAPS_STEP 10'h040

// Transmit volume: +30 dB at code 0, 3 dB per step, unity at 1010, mute at 1111
`define ECH_VOL_MAX_DB 7'sh1e
`define ECH_VOL_STEP_DB 7'sh03
`define ECH_VOL_UNITY 4'ha
`define ECH_VOL_MUTE 4'hf

// Receive suppression depth
`define ECH_SQUELCH_DB 5'h18

// Noise estimator rise rate base, dB per second
`define ECH_NOISE_RISE_BASE 4'h3

// Holdover times and clock rate
`define ECH_CLK_KHZ 100000
`define ECH_HOLD_200_MS 200
`define ECH_HOLD_100_MS 100
`define ECH_HOLD_150_MS 150

`endif

/* File: core/ech_pkg.sv */
// Types shared by the echo canceller control bank
package ech_pkg;

	typedef enum logic [1:0] {
		ECH_OWN_IDLE = 2'b00,
		ECH_OWN_TX = 2'b01,
		ECH_OWN_RX = 2'b10,
		ECH_OWN_HOLD = 2'b11
	} ech_owner_type;

	typedef enum logic [1:0] {
		ECH_LINE_ON = 2'b00,
		ECH_LINE_OFF = 2'b01,
		ECH_LINE_RETRAIN = 2'b10
	} ech_line_type;

	typedef enum logic [1:0] {
		ECH_COEFF_ADAPT = 2'b00,
		ECH_COEFF_CLEAR = 2'b01,
		ECH_COEFF_FREEZE = 2'b10
	} ech_coeff_type;

endpackage

/* File: core/ech_det_if.sv */
// Carrier between the bank and one speech detector
`timescale 1ns/1ps
interface ech_det_if;
	logic [7:0] power;
	logic [7:0] floor;
	logic [1:0] thr_code;
	logic speech;

	modport bank (output power, output floor, output thr_code, input speech);
	modport det (input power, input floor, input thr_code, output speech);
endinterface

/* File: core/ech_speech_det.sv */
// Speech detector: power above floor by a coded threshold
`timescale 1ns/1ps
`include "ech_defs.svh"
module ech_speech_det (
	input wire logic clk,
	input wire logic rst,
	ech_det_if.det port
);
	logic speech_reg;
	logic speech_next;
	logic [8:0] thr_db;

	// Threshold of 6, 9 or 12 dB; the reserved code behaves as 12 dB
	always_comb begin
		thr_db = `ECH_THR_BASE_DB + (`ECH_THR_STEP_DB * 9'(port.thr_code));
		if (port.thr_code == 2'b11) begin
			thr_db = `ECH_THR_BASE_DB + (`ECH_THR_STEP_DB * 9'h002);
		end
		speech_next = {1'b0, port.power} > ({1'b0, port.floor} + thr_db);
	end

	// Registered flag
	always_ff @(posedge clk) begin
		if (rst) begin
			speech_reg <= 1'b0;
		end else begin
			speech_reg <= speech_next;
		end
	end

	assign port.speech = speech_reg;
endmodule // ech_speech_det

/* File: core/ech_ctrl_regs.sv */
// Echo canceller control bank: two control words, detectors and control engines
`timescale 1ns/1ps
`include "ech_defs.svh"
module ech_ctrl_regs #(
	parameter int unsigned HOLD_200_CYC = `ECH_HOLD_200_MS * `ECH_CLK_KHZ,
	parameter int unsigned HOLD_100_CYC = `ECH_HOLD_100_MS * `ECH_CLK_KHZ,
	parameter int unsigned HOLD_150_CYC = `ECH_HOLD_150_MS * `ECH_CLK_KHZ,
	parameter int unsigned HOLD_W = 25
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic [7:0] tx_power_db,
	input wire logic [7:0] tx_floor_db,
	input wire logic [7:0] rx_power_db,
	input wire logic [7:0] rx_floor_db,
	input wire logic [1:0] line_far_noise_setting,
	input wire logic line_path_present,
	input wire logic line_trained,
	input wire logic howl_event,
	input wire logic acoustic_trained,
	output logic tx_speech,
	output logic rx_speech,
	output logic [9:0] acoustic_canceller_taps,
	output logic [9:0] line_canceller_taps,
	output logic signed [6:0] tx_gain_db,
	output logic tx_mute,
	output logic tx_agc_active,
	output logic [4:0] rx_atten_db,
	output logic line_coeff_clear,
	output logic line_coeff_freeze,
	output logic line_canceller_en,
	output logic line_retrain,
	output logic half_duplex,
	output logic [1:0] channel_owner,
	output logic [3:0] noise_estimate_rise_rate,
	output logic tx_doubletalk_decay,
	output logic rx_doubletalk_decay
);
	// Speech detector carriers
	ech_det_if tx_det ();
	ech_det_if rx_det ();
	ech_det_if sq_det ();

	logic [15:0] word1_reg;
	logic [15:0] word1_next;
	logic [15:0] word2_reg;
	logic [15:0] word2_next;
	logic ack_reg;
	logic ack_next;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;
	logic bus_req;
	logic wr_cmd;

	ech_pkg::ech_owner_type own_reg;
	ech_pkg::ech_owner_type own_next;
	ech_pkg::ech_owner_type last_reg;
	ech_pkg::ech_owner_type last_next;
	logic [HOLD_W-1:0] hold_cnt_reg;
	logic [HOLD_W-1:0] hold_cnt_next;
	logic [HOLD_W-1:0] hold_len;

	ech_pkg::ech_line_type line_reg;
	ech_pkg::ech_line_type line_next;
	logic howl_hd_reg;
	logic howl_hd_next;

	logic [9:0] ac_taps_reg;
	logic [9:0] ac_taps_next;
	logic [9:0] ln_taps_reg;
	logic [9:0] ln_taps_next;
	logic signed [6:0] gain_reg;
	logic signed [6:0] gain_next;
	logic mute_reg;
	logic mute_next;
	logic agc_reg;
	logic agc_next;
	logic [4:0] atten_reg;
	logic [4:0] atten_next;
	logic [3:0] rise_reg;
	logic [3:0] rise_next;

	// Detectors for transmit, receive and the receive squelch
	ech_speech_det u_tx_det (.clk(clk), .rst(rst), .port(tx_det.det));
	ech_speech_det u_rx_det (.clk(clk), .rst(rst), .port(rx_det.det));
	ech_speech_det u_sq_det (.clk(clk), .rst(rst), .port(sq_det.det));

	// Detector inputs
	assign tx_det.power = tx_power_db;
	assign tx_det.floor = tx_floor_db;
	assign tx_det.thr_code = word1_reg[`ECH_W1_TX_THR];
	assign rx_det.power = rx_power_db;
	assign rx_det.floor = rx_floor_db;
	assign rx_det.thr_code = word2_reg[`ECH_W2_RX_THR];
	assign sq_det.power = rx_power_db;
	assign sq_det.floor = rx_floor_db;
	assign sq_det.thr_code = word2_reg[`ECH_W2_SQUELCH_THR];

	// Bus handshake: one wait state on every access
	assign bus_req = avs_read | avs_write;
	assign avs_waitrequest = bus_req & ~ack_reg;
	assign wr_cmd = avs_write & ack_reg & (avs_address == `ECH_OFS_CMD) & (&avs_byteenable[1:0]);

	// Register file and read mux
	always_comb begin
		ack_next = bus_req & ~ack_reg;
		word1_next = word1_reg;
		word2_next = word2_reg;
		if (wr_cmd && avs_writedata[`ECH_CODE_FIELD] == `ECH_CODE_WORD1) begin
			word1_next = avs_writedata[15:0];
		end
		if (wr_cmd && avs_writedata[`ECH_CODE_FIELD] == `ECH_CODE_WORD2) begin
			word2_next = avs_writedata[15:0];
		end
		rdata_next = rdata_reg;
		if (avs_read && !ack_reg) begin
			case (avs_address)
				`ECH_OFS_WORD1: rdata_next = {16'h0000, word1_reg};
				`ECH_OFS_WORD2: rdata_next = {16'h0000, word2_reg};
				`ECH_OFS_STAT: rdata_next = {22'h000000, line_reg, own_reg, howl_hd_reg, half_duplex,
					sq_det.speech, rx_det.speech, tx_det.speech, line_canceller_en};
				default: rdata_next = 32'h00000000;
			endcase
		end
	end

	// Register file flops
	always_ff @(posedge clk) begin
		if (rst) begin
			word1_reg <= `ECH_WORD1_RST;
			word2_reg <= `ECH_WORD2_RST;
			ack_reg <= 1'b0;
			rdata_reg <= 32'h00000000;
		end else begin
			word1_reg <= word1_next;
			word2_reg <= word2_next;
			ack_reg <= ack_next;
			rdata_reg <= rdata_next;
		end
	end

	assign avs_readdata = rdata_reg;

	// Decoded settings; reserved codes fall back to the nearest defined setting
	always_comb begin
		ln_taps_next = `ECH_TAPS_STEP * (10'(word1_reg[`ECH_W1_TAPS]) + 10'h001);
		ac_taps_next = `ECH_TAPS_TOTAL - ln_taps_next;
		mute_next = word1_reg[`ECH_W1_TX_GAIN] == `ECH_VOL_MUTE;
		gain_next = `ECH_VOL_MAX_DB - (`ECH_VOL_STEP_DB * $signed({3'b000, word1_reg[`ECH_W1_TX_GAIN]}));
		agc_next = word1_reg[`ECH_W1_TX_GAIN] < `ECH_VOL_UNITY;
		// Squelch in unless enabled off or far speech is detected
		if (!word1_reg[`ECH_W1_SQUELCH_OFF] && !sq_det.speech) begin
			atten_next = `ECH_SQUELCH_DB;
		end else begin
			atten_next = 5'h00;
		end
		if (word2_reg[`ECH_W2_NOISE_RISE] == 2'b11) begin
			rise_next = `ECH_NOISE_RISE_BASE << 2;
		end else begin
			rise_next = `ECH_NOISE_RISE_BASE << word2_reg[`ECH_W2_NOISE_RISE];
		end
	end

	// Decoded settings flops
	always_ff @(posedge clk) begin
		if (rst) begin
			ln_taps_reg <= 10'h0c0;
			ac_taps_reg <= 10'h13c;
			gain_reg <= 7'sh00;
			mute_reg <= 1'b0;
			agc_reg <= 1'b0;
			atten_reg <= `ECH_SQUELCH_DB;
			rise_reg <= `ECH_NOISE_RISE_BASE;
		end else begin
			ln_taps_reg <= ln_taps_next;
			ac_taps_reg <= ac_taps_next;
			gain_reg <= gain_next;
			mute_reg <= mute_next;
			agc_reg <= agc_next;
			atten_reg <= atten_next;
			rise_reg <= rise_next;
		end
	end

	assign acoustic_canceller_taps = ac_taps_reg;
	assign line_canceller_taps = ln_taps_reg;
	assign tx_gain_db = gain_reg;
	assign tx_mute = mute_reg;
	assign tx_agc_active = agc_reg;
	assign rx_atten_db = atten_reg;
	assign noise_estimate_rise_rate = rise_reg;
	assign tx_doubletalk_decay = word2_reg[`ECH_W2_TX_DECAY];
	assign rx_doubletalk_decay = word2_reg[`ECH_W2_RX_DECAY];
	// Retraining also clears the line coefficients
	assign line_coeff_clear = (word1_reg[`ECH_W1_COEFF] == ech_pkg::ECH_COEFF_CLEAR) | line_retrain;
	assign line_coeff_freeze = (word1_reg[`ECH_W1_COEFF] == ech_pkg::ECH_COEFF_FREEZE) & ~line_retrain;

	// Line canceller engine and howl hold
	always_comb begin
		line_next = line_reg;
		case (line_reg)
			ech_pkg::ECH_LINE_ON: begin
				if (!line_path_present && line_far_noise_setting != 2'b00) begin
					line_next = ech_pkg::ECH_LINE_OFF;
				end
			end
			ech_pkg::ECH_LINE_OFF: begin
				if (line_path_present && !word1_reg[`ECH_W1_REENGAGE_OFF]) begin
					line_next = ech_pkg::ECH_LINE_RETRAIN;
				end
			end
			ech_pkg::ECH_LINE_RETRAIN: begin
				if (line_trained) begin
					line_next = ech_pkg::ECH_LINE_ON;
				end
			end
			default: line_next = ech_pkg::ECH_LINE_ON;
		endcase
		// A howl event sets the hold and wins over release
		howl_hd_next = howl_hd_reg;
		if (howl_event) begin
			howl_hd_next = 1'b1;
		end else if (acoustic_trained && !word2_reg[`ECH_W2_HOWL_HOLD]) begin
			howl_hd_next = 1'b0;
		end
	end

	// Line canceller flops
	always_ff @(posedge clk) begin
		if (rst) begin
			line_reg <= ech_pkg::ECH_LINE_ON;
			howl_hd_reg <= 1'b0;
		end else begin
			line_reg <= line_next;
			howl_hd_reg <= howl_hd_next;
		end
	end

	assign line_canceller_en = line_reg != ech_pkg::ECH_LINE_OFF;
	assign line_retrain = line_reg == ech_pkg::ECH_LINE_RETRAIN;
	assign half_duplex = howl_hd_reg | line_retrain | ~acoustic_trained;

	// Holdover length from the delay field
	always_comb begin
		case (word2_reg[`ECH_W2_HOLDOVER])
			2'b01: hold_len = HOLD_W'(HOLD_100_CYC);
			2'b10: hold_len = HOLD_W'(HOLD_150_CYC);
			default: hold_len = HOLD_W'(HOLD_200_CYC);
		endcase
	end

	// Channel ownership engine, active only in half duplex
	always_comb begin
		own_next = own_reg;
		last_next = last_reg;
		hold_cnt_next = hold_cnt_reg;
		if (!half_duplex) begin
			own_next = ech_pkg::ECH_OWN_IDLE;
			hold_cnt_next = '0;
		end else begin
			case (own_reg)
				ech_pkg::ECH_OWN_IDLE: begin
					if (tx_det.speech || word2_reg[`ECH_W2_IDLE_TX]) begin
						own_next = ech_pkg::ECH_OWN_TX;
					end else if (rx_det.speech) begin
						own_next = ech_pkg::ECH_OWN_RX;
					end
				end
				ech_pkg::ECH_OWN_TX, ech_pkg::ECH_OWN_RX: begin
					if ((own_reg == ech_pkg::ECH_OWN_TX) ? !tx_det.speech : !rx_det.speech) begin
						last_next = own_reg;
						own_next = ech_pkg::ECH_OWN_HOLD;
						hold_cnt_next = hold_len;
					end
				end
				ech_pkg::ECH_OWN_HOLD: begin
					// Only the former owner may resume while the hold runs
					if ((last_reg == ech_pkg::ECH_OWN_TX) ? tx_det.speech : rx_det.speech) begin
						own_next = last_reg;
					end else if (hold_cnt_reg <= HOLD_W'(1)) begin
						own_next = ech_pkg::ECH_OWN_IDLE;
						hold_cnt_next = '0;
					end else begin
						hold_cnt_next = hold_cnt_reg - HOLD_W'(1);
					end
				end
				default: own_next = ech_pkg::ECH_OWN_IDLE;
			endcase
		end
	end

	// Ownership flops
	always_ff @(posedge clk) begin
		if (rst) begin
			own_reg <= ech_pkg::ECH_OWN_IDLE;
			last_reg <= ech_pkg::ECH_OWN_TX;
			hold_cnt_reg <= '0;
		end else begin
			own_reg <= own_next;
			last_reg <= last_next;
			hold_cnt_reg <= hold_cnt_next;
		end
	end

	assign channel_owner = own_reg;
	assign tx_speech = tx_det.speech;
	assign rx_speech = rx_det.speech;
endmodule // ech_ctrl_regs

/* File: tb/ech_host.sv */
// Host model: Avalon master that writes and reads control words
`timescale 1ns/1ps
module ech_host (
	input wire logic clk,
	input wire logic avs_waitrequest,
	input wire logic [31:0] avs_readdata,
	output logic [3:0] avs_address,
	output logic avs_read,
	output logic avs_write,
	output logic [31:0] avs_writedata,
	output logic [3:0] avs_byteenable
);
	// Idle bus at time zero
	initial begin
		avs_address = 4'h0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		avs_byteenable = 4'hf;
	end

	// One access, held until waitrequest is low at a rising edge
	task automatic xfer(input logic [3:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= d; // Caller puts the destination code in the low nibble
		avs_write <= w;
		avs_read <= !w;
		// Hold everything until the rising edge at which waitrequest is sampled low
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		avs_writedata <= ~d; // Released data no longer shows the word
	endtask
endmodule // ech_host

/* File: tb/ech_ctrl_regs_chk.sv */
// Port checker for the echo canceller control bank
`timescale 1ns/1ps
module ech_ctrl_regs_chk (
	input wire logic clk,
	input wire logic rst,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	input wire logic avs_waitrequest,
	input wire logic [1:0] line_far_noise_setting,
	input wire logic line_path_present,
	input wire logic [9:0] acoustic_canceller_taps,
	input wire logic [9:0] line_canceller_taps,
	input wire logic signed [6:0] tx_gain_db,
	input wire logic tx_mute,
	input wire logic tx_agc_active,
	input wire logic [4:0] rx_atten_db,
	input wire logic line_coeff_clear,
	input wire logic line_coeff_freeze,
	input wire logic line_canceller_en,
	input wire logic line_retrain,
	input wire logic half_duplex
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	// Accepted command write aimed at the first control word
	sequence w1_acc;
		avs_write && !avs_waitrequest && avs_address == 4'h0 && avs_byteenable[1:0] == 2'b11
			&& avs_writedata[3:0] == 4'h2;
	endsequence

	chk_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("access not answered after one wait state");
	chk_taps_split: assert property (w1_acc |-> ##2 (line_canceller_taps == 10'h040 * ({8'h0, $past(avs_writedata[13:12], 2)} + 10'h001) && acoustic_canceller_taps == 10'h1fc - line_canceller_taps))
		else $error("tap split wrong");
	chk_gain_step: assert property (w1_acc |-> ##2 tx_gain_db == 7'sh1e - 7'sh03 * $signed({3'h0, $past(avs_writedata[11:8], 2)}))
		else $error("transmit gain wrong");
	chk_mute_code: assert property (w1_acc |-> ##2 tx_mute == ($past(avs_writedata[11:8], 2) == 4'hf))
		else $error("mute wrong");
	chk_agc_unity: assert property (w1_acc |-> ##2 tx_agc_active == ($past(avs_writedata[11:8], 2) < 4'ha))
		else $error("gain control activity wrong");
	chk_squelch_off: assert property (w1_acc and avs_writedata[7] |-> ##2 rx_atten_db == 5'h00)
		else $error("receive suppression not disabled");
	chk_coeff_mode: assert property (w1_acc |=> line_coeff_clear == ($past(avs_writedata[6:5]) == 2'b01 || line_retrain) && line_coeff_freeze == ($past(avs_writedata[6:5]) == 2'b10 && !line_retrain))
		else $error("coefficient mode wrong");
	chk_line_off: assert property ($fell(line_canceller_en) |-> $past(line_far_noise_setting) != 2'b00 && !$past(line_path_present))
		else $error("line canceller off without cause");
	chk_retrain_hd: assert property ($rose(line_retrain) |-> half_duplex && line_coeff_clear && line_canceller_en)
		else $error("re-engage without half duplex and retraining");
endmodule // ech_ctrl_regs_chk

/* File: tb/testbench.sv */
// Self-checking testbench for the echo canceller control bank
`timescale 1ns/1ps
module testbench;
	typedef struct {logic [15:0] w1, w2; logic [7:0] tp, rp; logic ts, rs; logic [9:0] lt; logic signed [6:0] g; logic [3:0] r;} ech_row_type;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [3:0] avs_address, avs_byteenable, rise;
	logic avs_read, avs_write, avs_waitrequest, seen;
	logic [31:0] avs_writedata, avs_readdata, q;
	logic [7:0] tp = 8'h00;
	logic [7:0] rp = 8'h00;
	logic [1:0] noise = 2'h0;
	logic path = 1'b1;
	logic trained = 1'b0;
	logic ac_tr = 1'b1;
	logic howl = 1'b0;
	logic tx_sp, rx_sp, mute, agc, clr, frz, len, ret, hd, txd, rxd;
	logic [9:0] at, lt;
	logic signed [6:0] gain;
	logic [4:0] att;
	logic [1:0] own;
	int bad_count = 0;
	int checked = 0;
	// Words, powers and the outputs they should give (floors at 32 dB)
	ech_row_type rows [5] = '{
		'{16'h0002, 16'h0004, 8'h27, 8'h26, 1'b1, 1'b0, 10'h040, 7'sh1e, 4'h3},
		'{16'h5e02, 16'h4404, 8'h29, 8'h2a, 1'b0, 1'b1, 10'h080, 7'sh74, 4'h6},
		'{16'haa02, 16'h8804, 8'h2d, 8'h2c, 1'b1, 1'b0, 10'h0c0, 7'sh00, 4'hc},
		'{16'h3702, 16'h8004, 8'h26, 8'h2d, 1'b0, 1'b1, 10'h100, 7'sh09, 4'h3},
		'{16'h0f02, 16'h0004, 8'h27, 8'h26, 1'b1, 1'b0, 10'h040, 7'sh71, 4'h3}};

	// Clock
	always #5 clk = ~clk;

	ech_host i_host (.clk, .avs_waitrequest, .avs_readdata, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_byteenable);

	ech_ctrl_regs #(.HOLD_200_CYC(40), .HOLD_100_CYC(20), .HOLD_150_CYC(30)) i_dut (
		.clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
		.avs_waitrequest, .tx_power_db(tp), .tx_floor_db(8'h20), .rx_power_db(rp), .rx_floor_db(8'h20),
		.line_far_noise_setting(noise), .line_path_present(path), .line_trained(trained), .howl_event(howl),
		.acoustic_trained(ac_tr), .tx_speech(tx_sp), .rx_speech(rx_sp), .acoustic_canceller_taps(at),
		.line_canceller_taps(lt), .tx_gain_db(gain), .tx_mute(mute), .tx_agc_active(agc), .rx_atten_db(att),
		.line_coeff_clear(clr), .line_coeff_freeze(frz), .line_canceller_en(len), .line_retrain(ret),
		.half_duplex(hd), .channel_owner(own), .noise_estimate_rise_rate(rise), .tx_doubletalk_decay(txd),
		.rx_doubletalk_decay(rxd));

	task automatic cmp(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e) begin
			bad_count++;
			$display("mismatch at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	// Let n edges pass, then settle at the falling edge
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask

	task automatic complete_run;
		if (bad_count == 0 && checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// Watchdog against a hung handshake
	initial begin
		repeat (5000) @(posedge clk);
		bad_count++;
		complete_run;
	end

	// Main sequence
	initial begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		step(0);
		cmp(lt, 10'h0c0);
		cmp(gain, 7'sh00);
		cmp(agc, 1'b0);
		cmp(att, 5'h18);
		cmp(own, 2'h0);
		i_host.xfer(4'h4, 1'b0, 32'h0, q);
		cmp(q, 32'h2a02);
		i_host.xfer(4'h8, 1'b0, 32'h0, q);
		cmp(q, 32'h0004);
		foreach (rows[i]) begin
			i_host.xfer(4'h0, 1'b1, {16'h0, rows[i].w1}, q);
			i_host.xfer(4'h0, 1'b1, {16'h0, rows[i].w2}, q);
			tp <= rows[i].tp;
			rp <= rows[i].rp;
			step(3);
			cmp(tx_sp, rows[i].ts);
			cmp(rx_sp, rows[i].rs);
			cmp(lt, rows[i].lt);
			cmp(at, 10'h1fc - rows[i].lt);
			cmp(gain, rows[i].g);
			cmp(mute, rows[i].w1[11:8] == 4'hf);
			cmp(rise, rows[i].r);
			cmp(att, (rows[i].rp > 8'h26) ? 5'h00 : 5'h18);
			i_host.xfer(4'h4, 1'b0, 32'h0, q);
			cmp(q, {16'h0, rows[i].w1});
			i_host.xfer(4'h8, 1'b0, 32'h0, q);
			cmp(q, {16'h0, rows[i].w2});
		end
		// Refused accesses leave the word alone; unmapped reads give zero
		i_host.xfer(4'h0, 1'b1, 32'h0000ffe3, q);
		i_host.xfer(4'h4, 1'b1, 32'h00000002, q);
		i_host.xfer(4'h4, 1'b0, 32'h0, q);
		cmp(q, 32'h0f02);
		i_host.xfer(4'h2, 1'b0, 32'h0, q);
		cmp(q, 32'h0);
		// Suppression disabled, each coefficient mode in turn
		for (int k = 0; k < 3; k++) begin
			i_host.xfer(4'h0, 1'b1, {16'h0, 8'h2a, 1'b1, 2'(k), 5'h02}, q);
			step(3);
			cmp(att, 5'h00);
			cmp(clr, k == 1);
			cmp(frz, k == 2);
		end
		// Line canceller switching
		@(posedge clk);
		path <= 1'b0;
		step(4);
		cmp(len, 1'b1);
		@(posedge clk);
		noise <= 2'h1;
		step(4);
		cmp(len, 1'b0);
		@(posedge clk);
		path <= 1'b1;
		step(4);
		cmp({len, ret, hd, clr}, 4'hf);
		@(posedge clk);
		trained <= 1'b1;
		step(4);
		cmp({len, ret}, 2'h2);
		i_host.xfer(4'h0, 1'b1, 32'h00002a12, q);
		@(posedge clk);
		path <= 1'b0;
		step(4);
		@(posedge clk);
		path <= 1'b1;
		step(4);
		cmp(len, 1'b0);
		// Half duplex ownership and holdover
		i_host.xfer(4'h0, 1'b1, 32'h00000164, q);
		@(posedge clk);
		ac_tr <= 1'b0;
		tp <= 8'h40;
		rp <= 8'h00;
		step(4);
		cmp({txd, rxd}, 2'h3);
		cmp(own, 2'h1);
		@(posedge clk);
		tp <= 8'h00;
		rp <= 8'h40;
		step(15);
		cmp(own, 2'h3);
		step(12);
		cmp(own, 2'h2);
		@(posedge clk);
		rp <= 8'h00;
		step(30);
		cmp(own, 2'h0);
		i_host.xfer(4'h0, 1'b1, 32'h00000174, q);
		seen = 1'b0;
		repeat (6) begin
			@(negedge clk);
			if (own === 2'h1) seen = 1'b1;
		end
		cmp(seen, 1'b1);
		// Howl with hold enabled keeps half duplex until the hold bit is cleared
		i_host.xfer(4'h0, 1'b1, 32'h00000084, q);
		@(posedge clk);
		ac_tr <= 1'b1;
		howl <= 1'b1;
		@(posedge clk);
		howl <= 1'b0;
		step(4);
		cmp(hd, 1'b1);
		i_host.xfer(4'h0, 1'b1, 32'h00000004, q);
		step(2);
		cmp(hd, 1'b0);
		// Reset in mid-run restores the reset words and the line canceller
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		step(0);
		cmp(len, 1'b1);
		cmp(att, 5'h18);
		i_host.xfer(4'h4, 1'b0, 32'h0, q);
		cmp(q, 32'h2a02);
		complete_run;
	end
endmodule // testbench

bind ech_ctrl_regs ech_ctrl_regs_chk i_chk (.clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
	.avs_byteenable, .avs_waitrequest, .line_far_noise_setting, .line_path_present, .acoustic_canceller_taps,
	.line_canceller_taps, .tx_gain_db, .tx_mute, .tx_agc_active, .rx_atten_db, .line_coeff_clear,
	.line_coeff_freeze, .line_canceller_en, .line_retrain, .half_duplex);
